// >>> core/mrp_map.svh
// Purpose: constants of the macrocell register bank
// Assumes: one system clock at 100 MHz
// Notes:   definitions only
`ifndef MRP_MAP_SVH
`define MRP_MAP_SVH

// -------------------------------------------------------------
// bank geometry
// -------------------------------------------------------------
`define MRP_NUM_REGS   20
`define MRP_NUM_CELLS  10
`define MRP_PAIR_SIZE  2

// -------------------------------------------------------------
// reset values, preset value and sync reset
// -------------------------------------------------------------
`define MRP_Q_RST      1'b0
`define MRP_PRESET_VAL 1'b1
`define MRP_SYNC_RST   2'h0

`endif

// >>> core/mrp_pkg.sv
// Purpose: types of the macrocell register bank
// Assumes: constants live in mrp_map.svh
// Notes:   used with scoped names only
package mrp_pkg;

   // clock source of one flip-flop
   typedef enum logic {
      MRP_CLK_TERM,
      MRP_CLK_PIN
   } mrp_clk_src_t;

   // storage kind of one flip-flop
   typedef enum logic {
      MRP_KIND_D,
      MRP_KIND_T
   } mrp_ff_kind_t;

endpackage : mrp_pkg

// >>> core/mrp_cell.sv
// Purpose: one macrocell flip-flop with clear, preset and preload
// Assumes: clock term edge already detected by the bank
// Notes:   clear wins over every other source
`timescale 1ns/10ps
`include "mrp_map.svh"

module mrp_cell (
   // clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 ce_i,
   // controls
   input  wire logic                 clk_edge_i,
   input  wire logic                 areset_i,
   input  wire logic                 preset_i,
   input  wire mrp_pkg::mrp_ff_kind_t kind_i,
   input  wire logic                 d_i,
   input  wire logic                 pl_en_i,
   input  wire logic                 pl_wr_i,
   input  wire logic                 pl_data_i,
   // state
   output logic                      q_o
);

   logic next_q;
   logic q;

   // d or t load from the sum term
   wire  load_val = (kind_i == mrp_pkg::MRP_KIND_T) ? (q ^ d_i) : d_i;

   // priority: clear, preload, preset, normal load
   always_comb begin
      next_q = q;
      if (areset_i) begin
         next_q = `MRP_Q_RST;
      end else if (clk_edge_i && pl_en_i) begin
         next_q = pl_wr_i ? pl_data_i : q;
      end else if (clk_edge_i && preset_i) begin
         next_q = `MRP_PRESET_VAL;
      end else if (clk_edge_i) begin
         next_q = load_val;
      end
   end

   // state flip-flop, cleared at power-up
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         q <= `MRP_Q_RST;
      end else if (ce_i) begin
         q <= next_q;
      end
   end

   assign q_o = q;

endmodule // mrp_cell

// >>> core/mrp_bank.sv
// Purpose: bank of twenty macrocell flip-flops, two per output cell
// Assumes: clock terms come from same-clock logic; pins are synchronised
// Notes:   clock terms act on their sampled rising edge
`timescale 1ns/10ps
`include "mrp_map.svh"

module mrp_bank (
   // clock, reset, enable
   input  wire logic                         clk_sys_i,
   input  wire logic                         rst_n_i,
   input  wire logic                         ce_i,
   // array terms, same clock domain
   input  wire logic [`MRP_NUM_REGS-1:0]     ck_term_i,
   input  wire logic [`MRP_NUM_REGS-1:0]     d_term_i,
   input  wire logic [`MRP_NUM_REGS-1:0]     areset_term_i,
   input  wire logic                         sync_preset_i,
   // configuration
   input  wire logic [`MRP_NUM_REGS-1:0]     clk_src_pin_i,
   input  wire logic [`MRP_NUM_REGS-1:0]     toggle_kind_i,
   input  wire logic [`MRP_NUM_CELLS-1:0]    second_register_feedback_select_i,
   input  wire logic                         legacy_mode_i,
   // device pins, asynchronous
   input  wire logic                         pin_clk_i,
   input  wire logic                         preload_en_i,
   input  wire logic                         preload_sel_i,
   input  wire logic [`MRP_NUM_CELLS-1:0]    io_pin_i,
   // register state and feedback
   output logic      [`MRP_NUM_REGS-1:0]     q_o,
   output logic      [`MRP_NUM_CELLS-1:0]    feedback_o
);

   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   localparam int SW = `MRP_NUM_CELLS + 3;

   logic [SW-1:0] sync_a;
   logic [SW-1:0] sync_b;

   // two stages; only sync_b is read by logic
   // pins move at any time, so the first stage may go metastable
   // and nothing but the second stage is allowed to look at it
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (ce_i) begin
         sync_a <= {pin_clk_i, preload_en_i, preload_sel_i, io_pin_i};
         sync_b <= sync_a;
      end
   end

   wire                      pin_clk_s = sync_b[SW-1];
   wire                      pl_en_s   = sync_b[SW-2];
   wire                      pl_sel_s  = sync_b[SW-3];
   wire [`MRP_NUM_CELLS-1:0] io_s      = sync_b[`MRP_NUM_CELLS-1:0];

   // ----------------------------------------------------------
   // clock selection and edge detection
   // ----------------------------------------------------------
   logic [`MRP_NUM_REGS-1:0] lvl_prev;
   logic [`MRP_NUM_REGS-1:0] q_state;

   // pin clocking and toggle disabled in legacy mode
   // legacy forces data-type loading through tog_sel
   wire [`MRP_NUM_REGS-1:0] pin_sel  = clk_src_pin_i & {`MRP_NUM_REGS{~legacy_mode_i}};
   wire [`MRP_NUM_REGS-1:0] tog_sel  = toggle_kind_i & {`MRP_NUM_REGS{~legacy_mode_i}};
   wire [`MRP_NUM_REGS-1:0] clk_lvl  = (pin_sel & {`MRP_NUM_REGS{pin_clk_s}})
                                     | (~pin_sel & ck_term_i);
   wire [`MRP_NUM_REGS-1:0] clk_edge = clk_lvl & ~lvl_prev;

   // previous clock level per register; history resets low, so a term
   // already high when reset lifts counts as a rising clock at once,
   // and a term must drop for one cycle before it can clock again
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         lvl_prev <= '0;
      end else if (ce_i) begin
         lvl_prev <= clk_lvl;
      end
   end

   // ----------------------------------------------------------
   // flip-flop array
   // ----------------------------------------------------------
   genvar r;
   generate
      for (r = 0; r < `MRP_NUM_REGS; r++) begin : g_ff
         // register r is number r%2 of cell r/2
         // both registers of a cell take preload data from the same pin
         wire pl_wr = ((r % `MRP_PAIR_SIZE) == 1) ? pl_sel_s : ~pl_sel_s;
         mrp_cell u_cell (
            .clk_sys_i  (clk_sys_i),
            .rst_n_i    (rst_n_i),
            .ce_i       (ce_i),
            .clk_edge_i (clk_edge[r]),
            .areset_i   (areset_term_i[r]),
            .preset_i   (sync_preset_i),
            .kind_i     (mrp_pkg::mrp_ff_kind_t'(tog_sel[r])),
            .d_i        (d_term_i[r]),
            .pl_en_i    (pl_en_s),
            .pl_wr_i    (pl_wr),
            .pl_data_i  (io_s[r / `MRP_PAIR_SIZE]),
            .q_o        (q_state[r])
         );
      end
   endgenerate

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   // clear term masks the state at once
   // the state itself empties on the next edge; the mask covers the
   // cycle in which the flip-flop still holds its old value
   assign q_o = q_state & ~areset_term_i;

   // feedback: second register only outside legacy mode
   genvar c;
   generate
      for (c = 0; c < `MRP_NUM_CELLS; c++) begin : g_fb
         assign feedback_o[c] = (second_register_feedback_select_i[c] && !legacy_mode_i)
                              ? q_o[2*c+1] : q_o[2*c];
      end
   endgenerate

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   generate
      for (r = 0; r < `MRP_NUM_REGS; r++) begin : g_chk
         // clear acts on the output now and on the state at the next edge
         chk_clear_now: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            ce_i && areset_term_i[r] |-> !q_o[r] ##1 !q_state[r])
            else $error("clear did not act at once");
         chk_clear_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            ce_i && areset_term_i[r] && sync_preset_i && clk_edge[r] |=> !q_state[r])
            else $error("clear lost to preset");
         // preset on a seen rising clock, hold without one
         chk_preset_edge: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            ce_i && sync_preset_i && clk_edge[r] && !areset_term_i[r] && !pl_en_s
            |=> q_state[r]) else $error("preset not loaded");
         chk_no_edge_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            ce_i && !clk_edge[r] && !areset_term_i[r] |=> q_state[r] == $past(q_state[r]))
            else $error("register moved without clock");
         // preload writes the chosen register and spares its partner
         chk_preload_pin: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            ce_i && pl_en_s && clk_edge[r] && !areset_term_i[r] && g_ff[r].pl_wr
            |=> q_state[r] == $past(io_s[r / `MRP_PAIR_SIZE]))
            else $error("preload value wrong");
         chk_preload_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            ce_i && pl_en_s && !g_ff[r].pl_wr && !areset_term_i[r]
            |=> q_state[r] == $past(q_state[r])) else $error("unselected changed");
         // normal load, data or toggle, and data only in legacy mode
         chk_data_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            ce_i && clk_edge[r] && !pl_en_s && !sync_preset_i && !areset_term_i[r]
            |=> q_state[r] == ($past(tog_sel[r]) ? $past(q_state[r]) ^ $past(d_term_i[r])
                                                  : $past(d_term_i[r])))
            else $error("normal load wrong");
         chk_legacy_dtype: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            ce_i && legacy_mode_i && clk_edge[r] && !pl_en_s && !sync_preset_i
            && !areset_term_i[r] |=> q_state[r] == $past(d_term_i[r]))
            else $error("toggle used in legacy");
      end
   endgenerate

   // clock source choice per register
   chk_legacy_clock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      legacy_mode_i |-> clk_lvl == ck_term_i) else $error("pin clock used in legacy");
   chk_pin_select: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !legacy_mode_i |-> clk_lvl == ((clk_src_pin_i & {`MRP_NUM_REGS{pin_clk_s}})
                                   | (~clk_src_pin_i & ck_term_i)))
      else $error("clock source wrong");

   // power-up clear of the whole bank
   chk_reset_zero: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> q_state == '0) else $error("reset did not clear");

   // legacy feedback always shows the first register of a cell
   generate
      for (c = 0; c < `MRP_NUM_CELLS; c++) begin : g_fb_chk
         chk_legacy_fb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
            legacy_mode_i |-> feedback_o[c] == q_o[2*c])
            else $error("feedback not first register in legacy");
      end
   endgenerate

   // pins reach the logic two enabled edges after they are sampled
   chk_pin_sync: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i ##1 ce_i |=> sync_b == $past({pin_clk_i, preload_en_i, preload_sel_i, io_pin_i}, 2))
      else $error("pin synchroniser delay wrong");

   // a low enable freezes every register and the synchroniser output
   chk_ce_freeze: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !ce_i |=> q_state == $past(q_state) && sync_b == $past(sync_b))
      else $error("state moved while enable low");

   // ----------------------------------------------------------
   // coverage of the main scenarios
   // ----------------------------------------------------------
   cov_preload_hi: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pl_en_s && pl_sel_s && clk_edge[1]);
   cov_preset_all: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      sync_preset_i && (&clk_edge));
   cov_clear_one: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      areset_term_i[3] && q_state[3]);
   cov_pin_clock: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && |(pin_sel & clk_edge));
   cov_legacy_load: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ce_i && legacy_mode_i && |clk_edge);

endmodule // mrp_bank

// >>> bench/mrp_array_model.sv
// Purpose: product-term array model making clock term pulses
// Assumes: fire_i and mask_i change at the falling edge
// Notes:   each request gives one high cycle, then a low cycle
`timescale 1ns/10ps

module mrp_array_model (
   // clock
   input  wire logic        clk_sys_i,
   // pulse request
   input  wire logic        fire_i,
   input  wire logic [19:0] mask_i,
   // clock terms to the bank
   output logic      [19:0] ck_term_o
);
   // terms idle low until the first request
   initial ck_term_o = 20'h00000;

   // one high cycle per request, low between rises
   always @(negedge clk_sys_i) begin
      ck_term_o <= fire_i ? mask_i : 20'h00000;
   end
endmodule // mrp_array_model

// >>> bench/mrp_bank_test.sv
// Purpose: self-checking bench of the macrocell register bank
// Assumes: inputs change at the falling edge; ce high except for one pulse in t_preset
// Notes:   pins get four cycles to cross the synchronisers
`timescale 1ns/10ps

module mrp_bank_test;
   logic        clk_sys_i, rst_n_i, ce, fire, sp, lm, pc, pe, ps;
   logic [19:0] msk, ck, d, ar, src, tk, q, e;
   logic [9:0]  fs, io, fb;
   int          err_total, checks_done, cyc;

   mrp_array_model arr (.clk_sys_i(clk_sys_i), .fire_i(fire), .mask_i(msk), .ck_term_o(ck));

   mrp_bank uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce), .ck_term_i(ck),
      .d_term_i(d), .areset_term_i(ar), .sync_preset_i(sp), .clk_src_pin_i(src),
      .toggle_kind_i(tk), .second_register_feedback_select_i(fs), .legacy_mode_i(lm),
      .pin_clk_i(pc), .preload_en_i(pe), .preload_sel_i(ps), .io_pin_i(io), .q_o(q),
      .feedback_o(fb));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task chk(input logic [19:0] s, input logic [19:0] x);
      checks_done++;
      if (s !== x) begin
         err_total++;
         $display("FAIL %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task nc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task pulse(input logic [19:0] m);
      msk <= m;
      fire <= 1'b1;
      nc(1);
      fire <= 1'b0;
      nc(3);
   endtask
   // one register of each pair, s selects second
   function automatic logic [19:0] half(input logic [19:0] v, input int s);
      half = 20'h00000;
      for (int c = 0; c < 10; c++) half[c] = v[2*c+s];
   endfunction
   task close_out;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_load;
      d <= 20'h5a5a6;
      pulse(20'hfffff);
      e = 20'h5a5a6;
      chk(q, e);
      tk <= 20'h00001;
      d <= 20'h5a5a7;
      pulse(20'h00001);
      e[0] = 1'b1;
      chk(q, e);
      lm <= 1'b1;
      d <= 20'h5a5a6;
      pulse(20'h00001);
      e[0] = 1'b0;
      chk(q, e);
      lm <= 1'b0;
      tk <= 20'h00000;
   endtask
   task t_pin;
      src <= 20'h00020;
      d <= e ^ 20'h00020;
      pulse(20'h00020);
      chk(q, e);
      pc <= 1'b1;
      nc(4);
      pc <= 1'b0;
      nc(4);
      e = e ^ 20'h00020;
      chk(q, e);
      lm <= 1'b1;
      d <= e ^ 20'h00020;
      pc <= 1'b1;
      nc(4);
      pc <= 1'b0;
      nc(4);
      chk(q, e);
      fs <= 10'h3ff;
      nc(1);
      chk({10'h000, fb}, half(e, 0));
      lm <= 1'b0;
      nc(1);
      chk({10'h000, fb}, half(e, 1));
      src <= 20'h00000;
   endtask
   task t_preset;
      sp <= 1'b1;
      d <= 20'h00000;
      nc(3);
      chk(q, e);
      ce <= 1'b0;
      pulse(20'hfffff);
      chk(q, e);
      ce <= 1'b1;
      pulse(20'hfffff);
      e = 20'hfffff;
      chk(q, e);
      ar <= 20'h00008;
      #1 chk(q, 20'hffff7);
      nc(1);
      pulse(20'hfffff);
      chk(q, 20'hffff7);
      ar <= 20'h00000;
      nc(2);
      e = 20'hffff7;
      chk(q, e);
   endtask
   task t_preload(input logic s, input logic [9:0] v);
      pe <= 1'b1;
      ps <= s;
      io <= v;
      nc(4);
      pulse(20'hfffff);
      for (int c = 0; c < 10; c++) e[2*c+s] = v[c];
      chk(q, e);
   endtask

   // ------------------------------------------------------------
   // clock, timeout, main sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      {rst_n_i, fire, sp, lm, pc, pe, ps} = 7'h00;
      {msk, d, ar, src, tk} = 100'h0;
      {fs, io} = 20'h00000;
      ce = 1'b1;
      nc(3);
      rst_n_i <= 1'b1;
      nc(1);
      chk(q, 20'h00000);
      t_load();
      t_pin();
      t_preset();
      t_preload(1'b0, 10'h155);
      t_preload(1'b1, 10'h0aa);
      close_out();
   end
endmodule // mrp_bank_test
